// ===== shared/gpf_pkg.sv
package gpf_pkg;

    // pin population and identifier width
    localparam int unsigned GPF_NUM_PINS = 9;
    localparam int unsigned GPF_ID_W = 5;
    localparam int unsigned GPF_PEND_W = 2;
    localparam logic [GPF_PEND_W-1:0] GPF_PEND_MAX = 2'h3;

    // register indices; byte address on the bus is four times the index
    localparam logic [9:0] GPF_IDX_BASE = 10'h2b0;
    localparam logic [9:0] GPF_IDX_LAST = 10'h2ca;
    localparam logic [1:0] GPF_SEL_A = 2'h0;
    localparam logic [1:0] GPF_SEL_B = 2'h1;
    localparam logic [1:0] GPF_SEL_C = 2'h2;

    // register A fields
    localparam int unsigned GPF_A_STRENGTH = 7;
    localparam int unsigned GPF_A_OUT = 4;
    localparam int unsigned GPF_A_IN = 3;
    localparam int unsigned GPF_A_RX_EN = 2;
    localparam int unsigned GPF_A_TX_EN = 1;
    localparam int unsigned GPF_A_DRV_DIS = 0;
    // register B fields
    localparam int unsigned GPF_B_PULL_LO = 6;
    localparam int unsigned GPF_B_TYPE = 5;
    // register C fields
    localparam int unsigned GPF_C_RECV = 6;

    // reset values; the low five bits of B and C take the pin index
    localparam logic [7:0] GPF_A_RESET = 8'h81;
    localparam logic [7:0] GPF_B_RESET = 8'ha0;
    localparam logic [7:0] GPF_C_RESET = 8'h40;

    // software-writable bits
    localparam logic [7:0] GPF_A_WMASK = 8'h97;
    localparam logic [7:0] GPF_B_WMASK = 8'hff;
    localparam logic [7:0] GPF_C_WMASK = 8'h1f;

    // pins limited to open-drain output or input
    localparam logic [GPF_NUM_PINS-1:0] GPF_ODI_MASK = 9'h018;

    typedef enum logic [1:0] {
        GPF_PULL_NONE = 2'b00,
        GPF_PULL_UP = 2'b01,
        GPF_PULL_DOWN = 2'b10,
        GPF_PULL_RSVD = 2'b11
    } gpf_pull_e;

    typedef enum logic {
        GPF_APB_IDLE = 1'b0,
        GPF_APB_DONE = 1'b1
    } gpf_apb_e;

    // state-change packet on the link
    typedef struct packed {
        logic [GPF_ID_W-1:0] id;
        logic value;
    } gpf_pkt_s;

    // pad controls of one pin
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_down;
        logic pull_high_res;
    } gpf_pad_s;

    typedef struct packed {
        logic hit;
        logic [3:0] pin;
        logic [1:0] sel;
    } gpf_dec_s;

    typedef struct packed {
        logic [GPF_NUM_PINS-1:0][7:0] reg_a;
        logic [GPF_NUM_PINS-1:0][7:0] reg_b;
        logic [GPF_NUM_PINS-1:0][GPF_ID_W-1:0] accept_tag;
        logic [GPF_NUM_PINS-1:0] recv;
        logic [GPF_NUM_PINS-1:0] sync1;
        logic [GPF_NUM_PINS-1:0] sync2;
        logic [GPF_NUM_PINS-1:0] prev;
        logic [GPF_NUM_PINS-1:0][GPF_PEND_W-1:0] pend;
        logic [GPF_NUM_PINS-1:0] sent;
        logic tx_valid;
        gpf_pkt_s tx_pkt;
        gpf_pad_s [GPF_NUM_PINS-1:0] pad;
        gpf_apb_e apb;
        logic err;
        logic [31:0] rdata;
    } gpf_state_s;

endpackage

// ===== design/gpf_gpio_link.sv
`timescale 1ns/100ps
module gpf_gpio_link
    import gpf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link status and packets
    input wire logic link_mode_current,
    output logic link_tx_valid,
    input wire logic link_tx_ready,
    output gpf_pkt_s link_tx_pkt,
    input wire logic link_rx_valid,
    input wire gpf_pkt_s link_rx_pkt,
    // multi_function_pin pads
    input wire logic [GPF_NUM_PINS-1:0] pin_in,
    output gpf_pad_s [GPF_NUM_PINS-1:0] pin_pad
);

    gpf_state_s s_q;
    gpf_state_s s_d;

    // index to pin and register select; groups of three in pin order
    function automatic gpf_dec_s gpf_decode(input logic [9:0] idx);
        gpf_dec_s r;
        logic [9:0] base;
        r = '0;
        for (int p = 0; p < GPF_NUM_PINS; p++) begin
            base = GPF_IDX_BASE + 10'(3 * p);
            for (int k = 0; k < 3; k++) begin
                if (idx == base + 10'(k)) begin
                    r.hit = 1'b1;
                    r.pin = 4'(p);
                    r.sel = 2'(k);
                end
            end
        end
        return r;
    endfunction

    function automatic gpf_state_s gpf_reset_state();
        gpf_state_s r;
        r = '0;
        for (int p = 0; p < GPF_NUM_PINS; p++) begin
            r.reg_a[p] = GPF_A_RESET;
            r.reg_b[p] = GPF_B_RESET | 8'(p);
            r.accept_tag[p] = GPF_ID_W'(p);
            r.recv[p] = GPF_C_RESET[GPF_C_RECV];
        end
        r.apb = GPF_APB_IDLE;
        return r;
    endfunction

    gpf_dec_s dec;
    logic [GPF_NUM_PINS-1:0] edge_seen;
    logic popped;
    logic granted;
    logic [3:0] grant_pin;
    logic level;
    logic push_pull;

    always_comb begin
        s_d = s_q;
        dec = gpf_decode(paddr[11:2]);
        level = 1'b0;
        push_pull = 1'b0;

        // input synchroniser; only sync2 onward is looked at
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        edge_seen = s_q.sync2 ^ s_q.prev;

        // transmit: one registered packet slot, refilled when empty
        popped = s_q.tx_valid & link_tx_ready;
        if (popped) begin
            s_d.tx_valid = 1'b0;
        end
        granted = 1'b0;
        grant_pin = '0;
        // fixed priority to the lowest pin; a busy low pin can delay higher ones
        for (int p = GPF_NUM_PINS - 1; p >= 0; p--) begin
            if (!s_q.tx_valid && s_q.pend[p] != '0 && s_q.reg_a[p][GPF_A_TX_EN] && link_mode_current) begin
                granted = 1'b1;
                grant_pin = 4'(p);
            end
        end
        if (granted) begin
            s_d.tx_valid = 1'b1;
            s_d.tx_pkt.id = s_q.reg_b[grant_pin][GPF_ID_W-1:0];
            s_d.tx_pkt.value = ~s_q.sent[grant_pin];
        end

        for (int p = 0; p < GPF_NUM_PINS; p++) begin
            if (!(s_q.reg_a[p][GPF_A_TX_EN] && link_mode_current)) begin
                // disabled: no backlog, and the far side is assumed to hold the current level
                s_d.pend[p] = '0;
                s_d.sent[p] = s_q.sync2[p];
            end else begin
                s_d.pend[p] = s_q.pend[p];
                if (granted && grant_pin == 4'(p)) begin
                    s_d.pend[p] = s_q.pend[p] - GPF_PEND_W'(1);
                    s_d.sent[p] = ~s_q.sent[p];
                end
                // saturate: past three outstanding changes, each extra edge is dropped
                if (edge_seen[p] && s_d.pend[p] != GPF_PEND_MAX) begin
                    s_d.pend[p] = s_d.pend[p] + GPF_PEND_W'(1);
                end
            end
        end

        // receive: while link_mode_current is high, every matching enabled pin takes the value
        if (link_rx_valid && link_mode_current) begin
            for (int p = 0; p < GPF_NUM_PINS; p++) begin
                if (s_q.reg_a[p][GPF_A_RX_EN] && s_q.accept_tag[p] == link_rx_pkt.id) begin
                    s_d.recv[p] = link_rx_pkt.value;
                end
            end
        end

        // pad controls
        for (int p = 0; p < GPF_NUM_PINS; p++) begin
            if (s_q.reg_a[p][GPF_A_RX_EN]) begin
                level = s_q.recv[p];
            end else begin
                level = s_q.reg_a[p][GPF_A_OUT];
            end
            push_pull = s_q.reg_b[p][GPF_B_TYPE] & ~GPF_ODI_MASK[p];
            s_d.pad[p].oe = ~s_q.reg_a[p][GPF_A_DRV_DIS] & (push_pull | ~level);
            s_d.pad[p].out = push_pull & level;
            s_d.pad[p].pull_high_res = s_q.reg_a[p][GPF_A_STRENGTH];
            case (gpf_pull_e'(s_q.reg_b[p][GPF_B_PULL_LO +: 2]))
                GPF_PULL_UP: begin
                    s_d.pad[p].pull_up = 1'b1;
                    s_d.pad[p].pull_down = 1'b0;
                end
                GPF_PULL_DOWN: begin
                    s_d.pad[p].pull_up = 1'b0;
                    s_d.pad[p].pull_down = 1'b1;
                end
                default: begin
                    // reserved code leaves the pin unpulled
                    s_d.pad[p].pull_up = 1'b0;
                    s_d.pad[p].pull_down = 1'b0;
                end
            endcase
        end

        // apb: one wait state so read data comes from a flop
        case (s_q.apb)
            GPF_APB_IDLE: begin
                if (psel && penable) begin
                    s_d.apb = GPF_APB_DONE;
                    s_d.err = ~dec.hit;
                    s_d.rdata = '0;
                    if (dec.hit) begin
                        case (dec.sel)
                            GPF_SEL_A: begin
                                s_d.rdata[7:0] = s_q.reg_a[dec.pin];
                                s_d.rdata[GPF_A_IN] = s_q.sync2[dec.pin];
                            end
                            GPF_SEL_B: begin
                                s_d.rdata[7:0] = s_q.reg_b[dec.pin];
                            end
                            default: begin
                                s_d.rdata[GPF_ID_W-1:0] = s_q.accept_tag[dec.pin];
                                s_d.rdata[GPF_C_RECV] = s_q.recv[dec.pin];
                            end
                        endcase
                    end
                end
            end
            GPF_APB_DONE: begin
                s_d.apb = GPF_APB_IDLE;
                if (psel && penable && pwrite && dec.hit && pstrb[0]) begin
                    case (dec.sel)
                        GPF_SEL_A: begin
                            s_d.reg_a[dec.pin] = (pwdata[7:0] & GPF_A_WMASK) | (s_q.reg_a[dec.pin] & ~GPF_A_WMASK);
                        end
                        GPF_SEL_B: begin
                            s_d.reg_b[dec.pin] = pwdata[7:0] & GPF_B_WMASK;
                        end
                        default: begin
                            // received value is read-only, so a write here never races the link
                            s_d.accept_tag[dec.pin] = pwdata[GPF_ID_W-1:0] & GPF_C_WMASK[GPF_ID_W-1:0];
                        end
                    endcase
                end
            end
            default: begin
                s_d.apb = GPF_APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= gpf_reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = (s_q.apb == GPF_APB_DONE);
    assign pslverr = (s_q.apb == GPF_APB_DONE) & s_q.err;
    assign link_tx_valid = s_q.tx_valid;
    assign link_tx_pkt = s_q.tx_pkt;
    assign pin_pad = s_q.pad;

endmodule

// ===== verification/gpf_gpio_link_chk.sv
`timescale 1ns/100ps
module gpf_gpio_link_chk
    import gpf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // link and pads
    input wire logic link_mode_current,
    input wire logic link_tx_valid,
    input wire logic link_tx_ready,
    input wire gpf_pkt_s link_tx_pkt,
    input wire gpf_pad_s [GPF_NUM_PINS-1:0] pin_pad
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    tx_hold_a: assert property (link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_pkt))
        else $error("offered packet changed before acceptance");
    tx_legacy_a: assert property (!link_mode_current [*3] |-> !$rose(link_tx_valid))
        else $error("packet offered in legacy mode");
    rdy_next_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered in one wait state");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_map_a: assert property (pslverr |-> pready && (paddr[11:2] < GPF_IDX_BASE || paddr[11:2] > GPF_IDX_LAST))
        else $error("error on a mapped register");
    hi_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    od_pin_a: assert property (!(pin_pad[3].oe && pin_pad[3].out) && !(pin_pad[4].oe && pin_pad[4].out))
        else $error("limited pin drives high");
    pull_one_a: assert property (!(pin_pad[0].pull_up && pin_pad[0].pull_down))
        else $error("both pull resistors on");

    cover property (link_tx_valid && link_tx_ready);
    cover property (link_tx_valid && !link_tx_ready ##1 link_tx_valid);
    cover property (pslverr);
endmodule

// ===== verification/gpf_far_end.sv
`timescale 1ns/100ps
module gpf_far_end
    import gpf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // link toward the block
    input wire logic link_tx_valid,
    input wire gpf_pkt_s link_tx_pkt,
    output logic link_tx_ready,
    output logic link_rx_valid,
    output gpf_pkt_s link_rx_pkt
);
    logic [3:0] cnt_q;
    int unsigned got_cnt;
    gpf_pkt_s got_pkt;

    initial begin
        link_rx_valid = 1'b0;
        link_rx_pkt = '0;
    end

    // slow acceptance forces the block to hold its offer and queue changes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            link_tx_ready <= 1'b0;
            cnt_q <= 4'h0;
            got_cnt <= 0;
        end else begin
            link_tx_ready <= 1'b0;
            if (link_tx_valid && !link_tx_ready) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q >= 4'h3) begin
                    link_tx_ready <= 1'b1;
                    cnt_q <= 4'h0;
                end
            end
            if (link_tx_valid && link_tx_ready) begin
                got_cnt <= got_cnt + 1;
                got_pkt <= link_tx_pkt;
            end
        end
    end

    task automatic send(input logic [GPF_ID_W-1:0] id, input logic value);
        link_rx_valid <= 1'b1;
        link_rx_pkt <= {id, value};
        @(posedge clk_sys);
        link_rx_valid <= 1'b0;
        // idle payload is inverted so a stale packet is never mistaken
        link_rx_pkt <= ~{id, value};
    endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    import gpf_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic link_mode_current = 1'b1;
    logic [GPF_NUM_PINS-1:0] pin_in = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_tx_valid;
    logic link_tx_ready;
    logic link_rx_valid;
    gpf_pkt_s link_tx_pkt;
    gpf_pkt_s link_rx_pkt;
    gpf_pad_s [GPF_NUM_PINS-1:0] pin_pad;
    logic [31:0] rdat;
    logic rerr;
    int bad_count = 0;
    int n_compared = 0;
    int unsigned g;

    always #10 clk_sys = ~clk_sys;

    gpf_gpio_link gpf_gpio_link_i (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .link_mode_current, .link_tx_valid, .link_tx_ready, .link_tx_pkt,
        .link_rx_valid, .link_rx_pkt, .pin_in, .pin_pad);
    gpf_far_end gpf_far_end_i (.clk_sys, .reset, .link_tx_valid, .link_tx_pkt, .link_tx_ready,
        .link_rx_valid, .link_rx_pkt);

    task automatic wrap_up;
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a slave that never answers is a failure, not a silent pass
        if (pready !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: no bus answer", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [9:0] ix(input int p, input int s);
        return GPF_IDX_BASE + 10'(3 * p + s);
    endfunction

    task automatic wr(input int p, input int s, input logic [7:0] d);
        apb(1'b1, ix(p, s), d);
    endtask

    task automatic rc(input int p, input int s, input logic [31:0] e);
        apb(1'b0, ix(p, s), 8'h0);
        chk(rdat, e);
    endtask

    task automatic pad(input int p, input logic [4:0] e, input logic [4:0] m);
        cy(3);
        chk(32'(pin_pad[p] & m), 32'(e));
    endtask

    task automatic toggle;
        pin_in[0] <= 1'b1;
        cy(3);
        pin_in[0] <= 1'b0;
    endtask

    task automatic wait_pkts(input int unsigned n);
        int k;
        k = 0;
        while (gpf_far_end_i.got_cnt < n && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        if (gpf_far_end_i.got_cnt < n) begin
            bad_count++;
            $display("unexpected at %0t: packet never arrived", $time);
        end
    endtask

    initial begin
        cy(5000);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        for (int p = 0; p < GPF_NUM_PINS; p++) begin
            rc(p, 0, 32'h81);
            rc(p, 1, 32'ha0 | 32'(p));
            rc(p, 2, 32'h40 | 32'(p));
        end
        apb(1'b0, GPF_IDX_LAST + 10'h1, 8'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        pad(0, 5'b00011, 5'h0f);
        wr(0, 0, 8'h10);
        pad(0, 5'b11010, 5'h1f);
        wr(0, 1, 8'h40);
        pad(0, 5'b00100, 5'h0f);
        wr(0, 1, 8'he0);
        pad(0, 5'b11000, 5'h1f);
        wr(0, 1, 8'ha0);
        wr(0, 0, 8'h90);
        pad(0, 5'b11011, 5'h1f);
        wr(0, 0, 8'h91);
        pad(0, 5'b00011, 5'h0f);
        wr(3, 1, 8'h23);
        wr(3, 0, 8'h00);
        pad(3, 5'b01000, 5'h1f);
        wr(3, 0, 8'h10);
        pad(3, 5'b00000, 5'h0f);
        // receivers are set up before any transmitter is enabled
        wr(1, 2, 8'h05);
        wr(1, 1, 8'h21);
        wr(1, 0, 8'h04);
        wr(2, 2, 8'h05);
        wr(2, 1, 8'h22);
        wr(2, 0, 8'h04);
        gpf_far_end_i.send(5'h05, 1'b0);
        pad(1, 5'b01000, 5'h1f);
        rc(1, 2, 32'h05);
        gpf_far_end_i.send(5'h06, 1'b1);
        pad(1, 5'b01000, 5'h1f);
        gpf_far_end_i.send(5'h05, 1'b1);
        pad(1, 5'b11000, 5'h1f);
        pad(2, 5'b11000, 5'h1f);
        gpf_far_end_i.send(5'h05, 1'b0);
        pad(2, 5'b01000, 5'h1f);
        link_mode_current <= 1'b0;
        gpf_far_end_i.send(5'h05, 1'b1);
        pad(1, 5'b01000, 5'h1f);
        link_mode_current <= 1'b1;
        wr(1, 0, 8'h10);
        pad(1, 5'b11000, 5'h1f);
        wr(0, 1, 8'h2b);
        wr(0, 0, 8'h02);
        g = gpf_far_end_i.got_cnt;
        toggle();
        wait_pkts(g + 1);
        chk(32'(gpf_far_end_i.got_pkt), 32'h17);
        wait_pkts(g + 2);
        chk(32'(gpf_far_end_i.got_pkt), 32'h16);
        wr(0, 0, 8'h00);
        toggle();
        cy(30);
        chk(gpf_far_end_i.got_cnt, g + 2);
        link_mode_current <= 1'b0;
        wr(0, 0, 8'h02);
        toggle();
        cy(30);
        chk(gpf_far_end_i.got_cnt, g + 2);
        wrap_up();
    end
endmodule

bind gpf_gpio_link gpf_gpio_link_chk gpf_gpio_link_chk_i (.clk_sys, .reset, .psel, .penable, .paddr, .prdata,
    .pready, .pslverr, .link_mode_current, .link_tx_valid, .link_tx_ready, .link_tx_pkt, .pin_pad);
